// file: common/adrres_defines.vh
// Register offsets, field positions and reset values of the address resolver register bank.
// Assumes a 32-bit Avalon-MM slave with byte addresses; included by bare name.
`ifndef ADRRES_DEFINES_VH
`define ADRRES_DEFINES_VH
`define ADRRES_OFS_START 12'h000
`define ADRRES_OFS_STOP 12'h008
`define ADRRES_OFS_EV_DONE 12'h100
`define ADRRES_OFS_EV_MATCH 12'h104
`define ADRRES_OFS_EV_NOMATCH 12'h108
`define ADRRES_OFS_IRQ_SET 12'h304
`define ADRRES_OFS_IRQ_CLR 12'h308
`define ADRRES_OFS_STATUS 12'h400
`define ADRRES_OFS_ENABLE 12'h500
`define ADRRES_OFS_KEYCNT 12'h504
`define ADRRES_OFS_KEYPTR 12'h508
`define ADRRES_OFS_TGTPTR 12'h510
`define ADRRES_OFS_SCRPTR 12'h514
`define ADRRES_BIT_DONE 0
`define ADRRES_BIT_MATCH 1
`define ADRRES_BIT_NOMATCH 2
`define ADRRES_ENABLE_ON 2'h3
`define ADRRES_ENABLE_OFF 2'h0
`define ADRRES_RST_KEYCNT 5'h01
`define ADRRES_RST_ZERO 32'h0000_0000
`define ADRRES_KEYCNT_MAX 5'h10
`define ADRRES_KEY_BYTES 32'h0000_0010
`endif

// file: core/adrres_regs.v
// Address resolver register bank with Avalon-MM slave, events, interrupt and resolver hooks.
// Assumes a resolution core outside that reports per-key results through res_key_* ports.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`include "adrres_defines.vh"
module adrres_regs (
    input wire clock,
    input wire arst_n,
    input wire [11:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg irq,
    output reg busy,
    output reg key_req,
    output reg [31:0] key_addr,
    output reg [31:0] target_addr,
    output reg [31:0] scratch_addr,
    input wire res_key_valid,
    input wire res_key_match
);
    localparam ST_IDLE = 2'd0;
    localparam ST_REQ = 2'd1;
    localparam ST_WAIT = 2'd2;

    reg [1:0] state_ff;
    reg [1:0] enable_ff;
    reg [4:0] keycnt_ff;
    reg [31:0] keyptr_ff;
    reg [31:0] tgtptr_ff;
    reg [31:0] scrptr_ff;
    reg [2:0] irqen_ff;
    reg [2:0] event_ff;
    reg [3:0] status_ff;
    reg [4:0] keyidx_ff;
    reg ack_ff;
    reg [2:0] nxt_event;
    reg [31:0] nxt_rdata;

    wire acc = (avs_read | avs_write) & ~ack_ff;
    wire wr = avs_write & ~ack_ff;
    wire full_wr = wr & (&avs_byteenable);
    wire run = (enable_ff == `ADRRES_ENABLE_ON);
    wire start_hit = full_wr & (avs_address == `ADRRES_OFS_START) & avs_writedata[0];
    wire stop_hit = full_wr & (avs_address == `ADRRES_OFS_STOP) & avs_writedata[0];
    wire last_key = (keyidx_ff + 5'd1 >= keycnt_ff);
    wire fin_match = (state_ff == ST_WAIT) & res_key_valid & res_key_match;
    wire fin_nomatch = (state_ff == ST_WAIT) & res_key_valid & ~res_key_match & last_key;

    function [31:0] wmerge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] be;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                wmerge[i*8 +: 8] = be[i] ? data[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    function wr_hit;
        input [11:0] ofs;
        begin
            wr_hit = wr & (avs_address == ofs);
        end
    endfunction

    // Event flags: hardware set beats software clear
    always @* begin
        nxt_event = event_ff;
        if (wr_hit(`ADRRES_OFS_EV_DONE) & avs_byteenable[0] & ~avs_writedata[0])
            nxt_event[`ADRRES_BIT_DONE] = 1'b0;
        if (wr_hit(`ADRRES_OFS_EV_MATCH) & avs_byteenable[0] & ~avs_writedata[0])
            nxt_event[`ADRRES_BIT_MATCH] = 1'b0;
        if (wr_hit(`ADRRES_OFS_EV_NOMATCH) & avs_byteenable[0] & ~avs_writedata[0])
            nxt_event[`ADRRES_BIT_NOMATCH] = 1'b0;
        if (fin_match | fin_nomatch)
            nxt_event[`ADRRES_BIT_DONE] = 1'b1;
        if (fin_match)
            nxt_event[`ADRRES_BIT_MATCH] = 1'b1;
        if (fin_nomatch)
            nxt_event[`ADRRES_BIT_NOMATCH] = 1'b1;
    end

    // Read mux
    always @* begin
        nxt_rdata = `ADRRES_RST_ZERO;
        case (avs_address)
            `ADRRES_OFS_EV_DONE: nxt_rdata[0] = event_ff[`ADRRES_BIT_DONE];
            `ADRRES_OFS_EV_MATCH: nxt_rdata[0] = event_ff[`ADRRES_BIT_MATCH];
            `ADRRES_OFS_EV_NOMATCH: nxt_rdata[0] = event_ff[`ADRRES_BIT_NOMATCH];
            `ADRRES_OFS_IRQ_SET: nxt_rdata[2:0] = irqen_ff;
            `ADRRES_OFS_IRQ_CLR: nxt_rdata[2:0] = irqen_ff;
            `ADRRES_OFS_STATUS: nxt_rdata[3:0] = status_ff;
            `ADRRES_OFS_ENABLE: nxt_rdata[1:0] = enable_ff;
            `ADRRES_OFS_KEYCNT: nxt_rdata[4:0] = keycnt_ff;
            `ADRRES_OFS_KEYPTR: nxt_rdata = keyptr_ff;
            `ADRRES_OFS_TGTPTR: nxt_rdata = tgtptr_ff;
            `ADRRES_OFS_SCRPTR: nxt_rdata = scrptr_ff;
            default: nxt_rdata = `ADRRES_RST_ZERO;
        endcase
    end

    // Bus slave: one wait cycle, answer on the second edge
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_ff <= 1'b0;
            avs_readdata <= `ADRRES_RST_ZERO;
        end else begin
            ack_ff <= acc;
            if (acc & avs_read)
                avs_readdata <= nxt_rdata;
        end
    end

    always @* avs_waitrequest = ~ack_ff & (avs_read | avs_write);

    // Configuration registers
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            enable_ff <= `ADRRES_ENABLE_OFF;
            keycnt_ff <= `ADRRES_RST_KEYCNT;
            keyptr_ff <= `ADRRES_RST_ZERO;
            tgtptr_ff <= `ADRRES_RST_ZERO;
            scrptr_ff <= `ADRRES_RST_ZERO;
            irqen_ff <= 3'h0;
            event_ff <= 3'h0;
        end else begin
            event_ff <= nxt_event;
            if (wr_hit(`ADRRES_OFS_ENABLE) & avs_byteenable[0])
                enable_ff <= avs_writedata[1:0];
            if (wr_hit(`ADRRES_OFS_KEYCNT) & avs_byteenable[0])
                keycnt_ff <= avs_writedata[4:0];
            if (wr_hit(`ADRRES_OFS_KEYPTR))
                keyptr_ff <= wmerge(keyptr_ff, avs_writedata, avs_byteenable);
            if (wr_hit(`ADRRES_OFS_TGTPTR))
                tgtptr_ff <= wmerge(tgtptr_ff, avs_writedata, avs_byteenable);
            if (wr_hit(`ADRRES_OFS_SCRPTR))
                scrptr_ff <= wmerge(scrptr_ff, avs_writedata, avs_byteenable);
            if (wr_hit(`ADRRES_OFS_IRQ_SET) & avs_byteenable[0])
                irqen_ff <= irqen_ff | avs_writedata[2:0];
            else if (wr_hit(`ADRRES_OFS_IRQ_CLR) & avs_byteenable[0])
                irqen_ff <= irqen_ff & ~avs_writedata[2:0];
        end
    end

    // Resolution sequencer walking the key table
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
            keyidx_ff <= 5'h00;
            status_ff <= 4'h0;
            busy <= 1'b0;
            key_req <= 1'b0;
            key_addr <= `ADRRES_RST_ZERO;
            target_addr <= `ADRRES_RST_ZERO;
            scratch_addr <= `ADRRES_RST_ZERO;
            irq <= 1'b0;
        end else begin
            irq <= |(nxt_event & irqen_ff);
            key_req <= 1'b0;
            if (stop_hit | ~run) begin
                state_ff <= ST_IDLE;
                busy <= 1'b0;
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        if (start_hit) begin
                            state_ff <= ST_REQ;
                            keyidx_ff <= 5'h00;
                            busy <= 1'b1;
                            key_addr <= keyptr_ff;
                            target_addr <= tgtptr_ff;
                            scratch_addr <= scrptr_ff;
                        end
                    end
                    ST_REQ: begin
                        key_req <= 1'b1;
                        state_ff <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        if (fin_match) begin
                            status_ff <= keyidx_ff[3:0];
                            state_ff <= ST_IDLE;
                            busy <= 1'b0;
                        end else if (fin_nomatch) begin
                            state_ff <= ST_IDLE;
                            busy <= 1'b0;
                        end else if (res_key_valid) begin
                            keyidx_ff <= keyidx_ff + 5'd1;
                            key_addr <= key_addr + `ADRRES_KEY_BYTES;
                            state_ff <= ST_REQ;
                        end
                    end
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// file: test/adrres_chk.sv
// Port checker for the resolver register bank.
// Assumes a bind into adrres_regs, whose port names it reuses.
`timescale 1ns/1ns
module adrres_chk (
    input wire clock,
    input wire arst_n,
    input wire [11:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire irq,
    input wire busy,
    input wire key_req
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire req = avs_read | avs_write;
    wire rd_ok = avs_read & ~avs_waitrequest;
    wire wr_ok = avs_write & ~avs_waitrequest;
    sequence one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    req_one_wait_a: assert property ($rose(req) |-> one_wait) else $error("wait not one cycle");
    idle_no_wait_a: assert property (!req |-> !avs_waitrequest) else $error("wait while idle");
    key_pulse_a: assert property (key_req |=> !key_req) else $error("key request long");
    key_after_busy_a: assert property (key_req |-> busy && $past(busy))
        else $error("key request while idle");
    stop_abort_a: assert property (wr_ok && avs_address == 12'h008 && avs_writedata[0]
        |-> ##[1:2] !busy) else $error("stop ignored");
    set_bits_a: assert property (rd_ok && avs_address == 12'h304
        |-> avs_readdata[31:3] == 29'h0000_0000) else $error("enable bits wide");
    status_range_a: assert property (rd_ok && avs_address == 12'h400
        |-> avs_readdata[31:4] == 28'h000_0000) else $error("status wide");
    enable_field_a: assert property (rd_ok && avs_address == 12'h500
        |-> avs_readdata[31:2] == 30'h0000_0000) else $error("enable wide");
    irq_off_a: assert property (wr_ok && avs_address == 12'h308 && avs_writedata[2:0] == 3'h7
        |-> ##[1:2] !irq) else $error("irq after clear");
endmodule

bind adrres_regs adrres_chk u_adrres_chk (.*);

// file: test/testbench.sv
// Self-checking bench for adrres_regs over Avalon-MM.
// Assumes the bench stands in for software and the resolution core.
`timescale 1ns/1ns
module testbench;
    reg clock;
    reg arst_n;
    reg [11:0] avs_address;
    reg avs_read;
    reg avs_write;
    reg [31:0] avs_writedata;
    reg [3:0] avs_byteenable;
    reg res_key_valid;
    reg res_key_match;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire irq;
    wire busy;
    wire key_req;
    wire [31:0] key_addr;
    wire [31:0] target_addr;
    wire [31:0] scratch_addr;
    integer fails;
    integer num_checks;
    reg [31:0] rdat;
    adrres_regs u_adrres_regs (.*);
    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, fails);
            if (fails == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    // Bus cycle held until the rising edge that samples waitrequest low
    task acc(input w, input [11:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge clock);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= w;
            avs_read <= !w;
            k = 0;
            @(posedge clock);
            while (avs_waitrequest && k < 20) begin
                @(posedge clock);
                k = k + 1;
            end
            rdat = avs_readdata;
            avs_write <= 0;
            avs_read <= 0;
            if (k >= 20) begin
                fails = fails + 1;
                $display("unexpected at %0t: bus answer missing", $time);
            end
        end
    endtask
    task rc(input [11:0] a, input [31:0] e);
        begin
            acc(0, a, 0);
            chk(rdat, e);
        end
    endtask
    // Start, then answer each key; key m matches
    task run(input integer n, input integer m);
        integer i;
        integer k;
        begin
            acc(1, 12'h000, 1);
            for (i = 0; i < n; i = i + 1) begin
                k = 0;
                while (!key_req && k < 50) begin
                    @(negedge clock);
                    k = k + 1;
                end
                chk(k < 50, 1);
                chk(key_addr, 32'h0000_4000 + 16 * i);
                @(posedge clock);
                res_key_valid <= 1;
                res_key_match <= (i == m);
                @(posedge clock);
                res_key_valid <= 0;
                if (i == m)
                    i = n;
            end
            chk(target_addr, 32'h0000_5000);
            chk(scratch_addr, 32'h0000_6000);
            repeat (3) @(negedge clock);
            chk(busy, 0);
        end
    endtask
    initial begin
        arst_n = 0;
        avs_address = 0;
        avs_read = 0;
        avs_write = 0;
        avs_writedata = 0;
        avs_byteenable = 4'hf;
        res_key_valid = 0;
        res_key_match = 0;
        fails = 0;
        num_checks = 0;
        repeat (6) @(posedge clock);
        arst_n <= 1;
        rc(12'h304, 0);
        rc(12'h400, 0);
        rc(12'h500, 0);
        rc(12'h504, 1);
        rc(12'h508, 0);
        rc(12'h510, 0);
        rc(12'h514, 0);
        acc(1, 12'h304, 32'hffff_ffff);
        rc(12'h308, 7);
        acc(1, 12'h308, 2);
        acc(1, 12'h304, 0);
        rc(12'h304, 5);
        acc(1, 12'h508, 32'h0000_4000);
        acc(1, 12'h510, 32'h0000_5000);
        acc(1, 12'h514, 32'h0000_6000);
        acc(1, 12'h504, 3);
        rc(12'h0fc, 0);
        acc(1, 12'h400, 9);
        rc(12'h400, 0);
        acc(1, 12'h000, 1);
        repeat (4) @(negedge clock);
        chk(busy, 0);
        $display("registers and enables done");
        acc(1, 12'h500, 3);
        run(3, 99);
        rc(12'h100, 1);
        rc(12'h104, 0);
        rc(12'h108, 1);
        chk(irq, 1);
        acc(1, 12'h100, 0);
        acc(1, 12'h108, 0);
        repeat (2) @(negedge clock);
        chk(irq, 0);
        $display("no match done");
        acc(1, 12'h504, 32'h0000_0010);
        rc(12'h504, 32'h0000_0010);
        acc(1, 12'h304, 2);
        run(16, 15);
        rc(12'h400, 15);
        rc(12'h104, 1);
        rc(12'h108, 0);
        chk(irq, 1);
        acc(1, 12'h308, 7);
        repeat (2) @(negedge clock);
        chk(irq, 0);
        acc(1, 12'h100, 0);
        acc(1, 12'h104, 0);
        $display("match done");
        acc(1, 12'h000, 1);
        acc(1, 12'h008, 1);
        repeat (2) @(negedge clock);
        chk(busy, 0);
        rc(12'h100, 0);
        $display("stop done");
        end_of_test;
    end
    initial begin
        repeat (20000) @(posedge clock);
        fails = fails + 1;
        end_of_test;
    end
endmodule
